// [include/usr_map.svh]
// Constants for the serial character block: field codes, reset values and timing.
`ifndef USR_MAP_SVH
`define USR_MAP_SVH
`define USR_PAR_EVEN      3'h0
`define USR_PAR_ODD       3'h1
`define USR_PAR_SPACE     3'h2
`define USR_PAR_MARK      3'h3
`define USR_PAR_NONE      3'h4
`define USR_PAR_MDROP_LO  3'h6
`define USR_PAR_MDROP_HI  3'h7
`define USR_CLK_NS        50
`define USR_BIT_NS_DEF    1000
`define USR_BAUD_DIV_DEF  ((`USR_BIT_NS_DEF + `USR_CLK_NS - 1) / `USR_CLK_NS)
`define USR_IDLE_RST      16'h0000
`endif

// [include/usr_pkg.sv]
// Types shared by the serial character block.
package usr_pkg;
    typedef struct packed {
        logic [2:0] check_bit_select;
        logic [3:0] char_len;
        logic       msb_first;
        logic       clocked_mode;
    } usr_mode_t;
    typedef struct packed {
        logic clear_status_cmd;
        logic send_address_cmd;
        logic wait_first_char_cmd;
        logic idle_reload_cmd;
    } usr_cmd_t;
    typedef struct packed {
        logic rx_char_avail;
        logic rx_overrun_flag;
        logic check_bit_error_flag;
        logic tx_holding_free;
        logic tx_all_done;
        logic rx_idle_flag;
    } usr_status_t;
    typedef enum logic [4:0] {
        TX_IDLE  = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA  = 5'b00100,
        TX_CHECK = 5'b01000,
        TX_STOP  = 5'b10000
    } usr_tx_state_t;
endpackage

// [verilog/usr_fifo.sv]
// Small valid/ready FIFO used on the transmit data path.
`timescale 1ns/1ps
`default_nettype none
module usr_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ff;
    logic [AW:0]      rd_ff;
    logic             push;
    logic             pop;
    assign in_ready  = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
    assign out_valid = wr_ff != rd_ff;
    assign out_data  = mem[rd_ff[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ff[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= wr_ff + (AW+1)'(push);
            rd_ff <= rd_ff + (AW+1)'(pop);
        end
    end
endmodule // usr_fifo
`default_nettype wire

// [verilog/usr_serial.sv]
// Clocked-mode serial port with check bits, multidrop, idle gap and receive idle time-out.
// Notes on behaviour
// - In clocked mode sample receive line each baud tick; low starts a character.
// - Clocked receiver uses the shared length, bit order and check-bit settings.
// - A finished character goes to the holding register and sets receive-available.
// - Character finishing while receive-available is set raises overrun and overwrites.
// - Clear-status command clears overrun and check-bit error flags.
// - Even mode: check bit equals data parity; receiver flags mismatch.
// - Odd mode: check bit is inverted parity; receiver flags mismatch.
// - Mark mode sends 1; receiving a 0 is an error.
// - Space mode sends 0; receiving a 1 is an error.
// - Disabled mode sends no check bit and never flags errors.
// - A check-bit error sets the check-bit error flag.
// - Select codes 6 and 7 mean multidrop: data check 0, address check 1.
// - In multidrop a high received check bit sets the error flag.
// - After send-address, the next written byte goes with check bit 1.
// - Nonzero idle gap holds the line high that many bit periods after stop.
// - With data waiting, holding-free stays low during the gap and rises when the gap count reaches zero, one bit period before the next start bit.
// - All-done stays low until the gap has been fully sent.
// - Idle limit zero disables time-out and keeps the idle flag low.
// - Nonzero limit loads a 16-bit down-counter per bit period; zero raises flag.
// - The receive idle flag is a status output usable as an interrupt.
// - Wait-first-char command stops the countdown until a character arrives.
// - Reload command restarts the countdown from the limit immediately.
`timescale 1ns/1ps
`default_nettype none
`include "usr_map.svh"
module usr_serial #(
    parameter int BAUD_DIV = `USR_BAUD_DIV_DEF,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire usr_pkg::usr_mode_t   mode_reg,
    input  wire logic [7:0]           idle_gap_reg,
    input  wire logic [15:0]          rx_idle_reg,
    input  wire usr_pkg::usr_cmd_t    control_reg,
    input  wire logic                 control_wr,
    input  wire logic [8:0]           tx_holding_reg,
    input  wire logic                 tx_wr,
    output logic                      tx_wr_ready,
    input  wire logic                 rx_read,
    output logic [8:0]                rx_holding_reg,
    output usr_pkg::usr_status_t      channel_status_reg,
    input  wire logic                 rxd,
    output logic                      txd,
    output logic                      baud_clk_out
);
    initial begin
        if (BAUD_DIV < 2 || BAUD_DIV > 65535) $error("BAUD_DIV out of range");
    end
    logic [15:0] div_ff;
    logic        tick_ff;
    logic        baud_ff;
    // The one tick paces the receiver, transmitter, gap and time-out alike.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_ff  <= 16'h0000;
            tick_ff <= 1'b0;
            baud_ff <= 1'b0;
        end else begin
            tick_ff <= div_ff == 16'(BAUD_DIV - 1);
            div_ff  <= (div_ff == 16'(BAUD_DIV - 1)) ? 16'h0000 : div_ff + 16'h0001;
            baud_ff <= div_ff < 16'(BAUD_DIV / 2);
        end
    end
    assign baud_clk_out = baud_ff;

    function automatic logic check_of(input logic [2:0] sel, input logic [8:0] d, input logic [3:0] len,
                                      input logic addr);
        logic [8:0] m;
        logic       p;
        m = 9'h1FF >> (4'd9 - len);
        p = ^(d & m);
        unique case (sel)
            `USR_PAR_EVEN:   check_of = p;
            `USR_PAR_ODD:    check_of = ~p;
            `USR_PAR_MARK:   check_of = 1'b1;
            `USR_PAR_SPACE:  check_of = 1'b0;
            default:         check_of = addr;
        endcase
    endfunction

    function automatic logic has_check(input logic [2:0] sel);
        has_check = sel != `USR_PAR_NONE && sel != 3'h5;
    endfunction

    // Transmit path: FIFO holds data plus the address mark chosen at write time.
    logic       addr_pend_ff;
    logic [9:0] f_in;
    logic [9:0] f_out;
    logic       f_valid;
    logic       f_ready;
    logic       f_in_ready;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            addr_pend_ff <= 1'b0;
        end else if (control_wr && control_reg.send_address_cmd) begin
            addr_pend_ff <= 1'b1;
        end else if (tx_wr && f_in_ready) begin
            addr_pend_ff <= 1'b0;
        end
    end
    assign f_in = {addr_pend_ff, tx_holding_reg};
    usr_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock     (clock),
        .nrst      (nrst),
        .in_data   (f_in),
        .in_valid  (tx_wr),
        .in_ready  (f_in_ready),
        .out_data  (f_out),
        .out_valid (f_valid),
        .out_ready (f_ready)
    );
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tx_wr_ready <= 1'b0;
        end else begin
            tx_wr_ready <= f_in_ready;
        end
    end

    usr_pkg::usr_tx_state_t tx_st_ff;
    logic [8:0]  tx_sh_ff;
    logic [3:0]  tx_cnt_ff;
    logic [7:0]  gap_ff;
    logic        tx_chk_ff;
    logic        txd_ff;
    assign f_ready = tick_ff && tx_st_ff == usr_pkg::TX_IDLE && gap_ff == 8'h00;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tx_st_ff  <= usr_pkg::TX_IDLE;
            tx_sh_ff  <= 9'h000;
            tx_cnt_ff <= 4'h0;
            gap_ff    <= 8'h00;
            tx_chk_ff <= 1'b0;
            txd_ff    <= 1'b1;
        end else if (tick_ff) begin
            unique case (tx_st_ff)
                usr_pkg::TX_IDLE: begin
                    txd_ff <= 1'b1;
                    if (gap_ff != 8'h00) begin
                        gap_ff <= gap_ff - 8'h01;
                    end else if (f_valid) begin
                        txd_ff    <= 1'b0;
                        tx_sh_ff  <= mode_reg.msb_first ?
                                     9'({<<{f_out[8:0]}} >> (4'd9 - mode_reg.char_len)) : f_out[8:0];
                        tx_chk_ff <= check_of(mode_reg.check_bit_select, f_out[8:0], mode_reg.char_len, f_out[9]);
                        tx_cnt_ff <= mode_reg.char_len;
                        tx_st_ff  <= usr_pkg::TX_DATA;
                    end
                end
                usr_pkg::TX_DATA: begin
                    txd_ff    <= tx_sh_ff[0];
                    tx_sh_ff  <= tx_sh_ff >> 1;
                    tx_cnt_ff <= tx_cnt_ff - 4'h1;
                    if (tx_cnt_ff == 4'h1) begin
                        tx_st_ff <= has_check(mode_reg.check_bit_select) ? usr_pkg::TX_CHECK : usr_pkg::TX_STOP;
                    end
                end
                usr_pkg::TX_CHECK: begin
                    txd_ff   <= tx_chk_ff;
                    tx_st_ff <= usr_pkg::TX_STOP;
                end
                usr_pkg::TX_STOP: begin
                    txd_ff   <= 1'b1;
                    gap_ff   <= idle_gap_reg;
                    tx_st_ff <= usr_pkg::TX_IDLE;
                end
                default: tx_st_ff <= usr_pkg::TX_IDLE;
            endcase
        end
    end
    assign txd = txd_ff;

    // Receiver, sampling once per baud tick in clocked mode.
    logic        rx_busy_ff;
    logic [3:0]  rx_cnt_ff;
    logic [8:0]  rx_sh_ff;
    logic        rx_chk_ph_ff;
    logic        rx_done;
    logic [8:0]  rx_word;
    logic        rx_bad;
    logic        rx_bit;
    logic [3:0]  rx_left;
    assign rx_bit  = rxd;
    assign rx_left = rx_cnt_ff - 4'h1;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_busy_ff   <= 1'b0;
            rx_cnt_ff    <= 4'h0;
            rx_sh_ff     <= 9'h000;
            rx_chk_ph_ff <= 1'b0;
        end else if (tick_ff && mode_reg.clocked_mode) begin
            if (!rx_busy_ff) begin
                if (!rx_bit) begin
                    rx_busy_ff   <= 1'b1;
                    rx_cnt_ff    <= mode_reg.char_len;
                    rx_chk_ph_ff <= 1'b0;
                    rx_sh_ff     <= 9'h000;
                end
            end else if (rx_cnt_ff != 4'h0) begin
                rx_sh_ff  <= mode_reg.msb_first ? {rx_sh_ff[7:0], rx_bit} : {rx_bit, rx_sh_ff[8:1]};
                rx_cnt_ff <= rx_left;
            end else if (has_check(mode_reg.check_bit_select) && !rx_chk_ph_ff) begin
                rx_chk_ph_ff <= 1'b1;
                rx_sh_ff     <= rx_sh_ff;
            end else begin
                rx_busy_ff <= 1'b0;
            end
        end
    end
    logic rx_chk_ff;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_chk_ff <= 1'b0;
        end else if (tick_ff && rx_busy_ff && rx_cnt_ff == 4'h0 && !rx_chk_ph_ff) begin
            rx_chk_ff <= rx_bit;
        end
    end
    assign rx_done = tick_ff && mode_reg.clocked_mode && rx_busy_ff && rx_cnt_ff == 4'h0 &&
                     (rx_chk_ph_ff || !has_check(mode_reg.check_bit_select));
    assign rx_word = mode_reg.msb_first ? rx_sh_ff : 9'(rx_sh_ff >> (4'd9 - mode_reg.char_len));
    always_comb begin
        rx_bad = 1'b0;
        if (has_check(mode_reg.check_bit_select)) begin
            if (mode_reg.check_bit_select[2]) begin
                rx_bad = rx_chk_ff;
            end else begin
                rx_bad = rx_chk_ff != check_of(mode_reg.check_bit_select, rx_word, mode_reg.char_len, 1'b0);
            end
        end
    end

    // Status flags: a set in the same cycle as a clear wins.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_holding_reg <= 9'h000;
            channel_status_reg.rx_char_avail        <= 1'b0;
            channel_status_reg.rx_overrun_flag      <= 1'b0;
            channel_status_reg.check_bit_error_flag <= 1'b0;
        end else begin
            if (rx_done) begin
                rx_holding_reg <= rx_word;
            end
            channel_status_reg.rx_char_avail <= rx_done || (channel_status_reg.rx_char_avail && !rx_read);
            if (rx_done && channel_status_reg.rx_char_avail && !rx_read) begin
                channel_status_reg.rx_overrun_flag <= 1'b1;
            end else if (control_wr && control_reg.clear_status_cmd) begin
                channel_status_reg.rx_overrun_flag <= 1'b0;
            end
            if (rx_done && rx_bad) begin
                channel_status_reg.check_bit_error_flag <= 1'b1;
            end else if (control_wr && control_reg.clear_status_cmd) begin
                channel_status_reg.check_bit_error_flag <= 1'b0;
            end
        end
    end

    // Holding-free reflects FIFO room and all-done waits for the gap to finish.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            channel_status_reg.tx_holding_free <= 1'b0;
            channel_status_reg.tx_all_done     <= 1'b0;
        end else begin
            channel_status_reg.tx_holding_free <= f_in_ready && !(f_valid && gap_ff != 8'h00);
            channel_status_reg.tx_all_done     <= !f_valid && tx_st_ff == usr_pkg::TX_IDLE &&
                                                  gap_ff == 8'h00 && !tx_wr;
        end
    end

    // Receive idle time-out.
    logic [15:0] to_ff;
    logic        to_run_ff;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            to_ff     <= `USR_IDLE_RST;
            to_run_ff <= 1'b0;
            channel_status_reg.rx_idle_flag <= 1'b0;
        end else if (rx_idle_reg == 16'h0000) begin
            to_run_ff <= 1'b0;
            channel_status_reg.rx_idle_flag <= 1'b0;
        end else if (rx_done) begin
            to_ff     <= rx_idle_reg;
            to_run_ff <= 1'b1;
        end else if (control_wr && control_reg.idle_reload_cmd) begin
            to_ff     <= rx_idle_reg;
            to_run_ff <= 1'b1;
            channel_status_reg.rx_idle_flag <= 1'b0;
        end else if (control_wr && control_reg.wait_first_char_cmd) begin
            to_run_ff <= 1'b0;
            channel_status_reg.rx_idle_flag <= 1'b0;
        end else if (to_run_ff && tick_ff) begin
            to_ff <= to_ff - 16'h0001;
            if (to_ff == 16'h0001) begin
                to_run_ff <= 1'b0;
                channel_status_reg.rx_idle_flag <= 1'b1;
            end
        end
    end

    a_idle_off_flag: assert property (@(posedge clock) disable iff (!nrst)
        rx_idle_reg == 16'h0000 |=> !channel_status_reg.rx_idle_flag) else $error("idle flag with limit zero");
    a_overrun_set: assert property (@(posedge clock) disable iff (!nrst)
        rx_done && channel_status_reg.rx_char_avail && !rx_read |=> channel_status_reg.rx_overrun_flag)
        else $error("overrun not raised");
    a_rx_avail_set: assert property (@(posedge clock) disable iff (!nrst)
        rx_done |=> channel_status_reg.rx_char_avail && rx_holding_reg == $past(rx_word))
        else $error("character not delivered");
    a_clear_status: assert property (@(posedge clock) disable iff (!nrst)
        control_wr && control_reg.clear_status_cmd && !rx_done |=> !channel_status_reg.rx_overrun_flag &&
        !channel_status_reg.check_bit_error_flag) else $error("clear status failed");
    a_none_no_error: assert property (@(posedge clock) disable iff (!nrst)
        rx_done && !has_check(mode_reg.check_bit_select) |-> !rx_bad) else $error("error without check bit");
    a_mark_check: assert property (@(posedge clock) disable iff (!nrst)
        tick_ff && tx_st_ff == usr_pkg::TX_CHECK && mode_reg.check_bit_select == `USR_PAR_MARK |=> txd)
        else $error("mark bit not high");
    a_gap_line_high: assert property (@(posedge clock) disable iff (!nrst)
        gap_ff != 8'h00 && tx_st_ff == usr_pkg::TX_IDLE |-> txd) else $error("line low in gap");
    a_gap_not_done: assert property (@(posedge clock) disable iff (!nrst)
        gap_ff != 8'h00 ##1 gap_ff != 8'h00 |-> !channel_status_reg.tx_all_done) else $error("done during gap");
    a_parity_flag: assert property (@(posedge clock) disable iff (!nrst)
        rx_done && rx_bad |=> channel_status_reg.check_bit_error_flag) else $error("error flag missed");
endmodule // usr_serial
`default_nettype wire

// [testbench/usr_remote.sv]
// Remote serial device model: drives the receive line and samples the transmit line.
`timescale 1ns/1ps
`default_nettype none
module usr_remote (
    input  wire logic clock,
    input  wire logic baud_clk,
    input  wire logic txd,
    output logic      rxd
);
    // The line idles high between frames, as a pulled-up serial line does.
    initial rxd = 1'b1;
    // Levels change half a clock after a tick, so the next tick samples a settled bit.
    task automatic step();
        @(posedge baud_clk);
        @(negedge clock);
    endtask
    task automatic send(input logic [8:0] d, input int n, input logic msb, input logic hc, input logic c);
        step();
        rxd = 1'b0;
        for (int i = 0; i < n; i++) begin
            step();
            rxd = msb ? d[n-1-i] : d[i];
        end
        if (hc) begin
            step();
            rxd = c;
        end
        step();
        rxd = 1'b1;
        step();
    endtask
    // Samples in mid-bit on a falling edge, clear of the edges that move the line.
    task automatic samp(output logic b);
        @(posedge baud_clk);
        @(posedge clock);
        @(negedge clock);
        b = txd;
    endtask
    task automatic recv(input int n, output logic [7:0] d, output logic c, output int gap);
        logic b;
        b = 1'b1;
        gap = -1;
        d = 8'h00;
        for (int k = 0; k < 400 && b === 1'b1; k++) begin
            samp(b);
            gap++;
        end
        for (int i = 0; i < n; i++) begin
            samp(b);
            d[i] = b;
        end
        samp(c);
        samp(b);
    endtask
endmodule // usr_remote
`default_nettype wire

// [testbench/test_usr_serial.sv]
// Self-checking bench for the serial character block.
`timescale 1ns/1ps
`default_nettype none
module test_usr_serial;
    localparam int DIV = 4;
    localparam int GAP = 2;
    logic                 clock;
    logic                 nrst;
    usr_pkg::usr_mode_t   mode;
    logic [7:0]           gap_len;
    logic [15:0]          idle_lim;
    usr_pkg::usr_cmd_t    cmd_bits;
    logic                 cmd_wr;
    logic [8:0]           tx_data;
    logic                 tx_wr;
    logic                 tx_rdy;
    logic                 rx_rd;
    logic [8:0]           rx_data;
    usr_pkg::usr_status_t st;
    logic                 rxd;
    logic                 txd;
    logic                 baud;
    int                   failures;
    int                   cmp_count;
    logic [7:0]           d;
    logic [7:0]           e;
    logic                 c;
    logic                 hc;
    int                   g;
    int                   n;
    usr_serial #(.BAUD_DIV(DIV), .FIFO_DEPTH(8)) usr_serial_i (
        .clock(clock), .nrst(nrst), .mode_reg(mode), .idle_gap_reg(gap_len), .rx_idle_reg(idle_lim),
        .control_reg(cmd_bits), .control_wr(cmd_wr), .tx_holding_reg(tx_data), .tx_wr(tx_wr),
        .tx_wr_ready(tx_rdy), .rx_read(rx_rd), .rx_holding_reg(rx_data), .channel_status_reg(st),
        .rxd(rxd), .txd(txd), .baud_clk_out(baud));
    usr_remote usr_remote_i (.clock(clock), .baud_clk(baud), .txd(txd), .rxd(rxd));
    initial clock = 1'b0;
    always #25 clock = ~clock;
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp_val(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_val({8'h00, got}, {8'h00, exp});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge baud);
        @(negedge clock);
    endtask
    task automatic command(input logic [3:0] v);
        cmd_bits = usr_pkg::usr_cmd_t'(v);
        cmd_wr = 1'b1;
        @(negedge clock);
        cmd_wr = 1'b0;
        @(negedge clock);
    endtask
    task automatic set_mode(input logic [2:0] m, input logic [3:0] len, input logic msb);
        mode = {m, len, msb, 1'b1};
        @(negedge clock);
    endtask
    task automatic write(input logic [8:0] v);
        int k;
        for (k = 0; k < 400 && tx_rdy !== 1'b1; k++) @(negedge clock);
        if (k == 400) begin
            failures++;
            results();
        end
        tx_data = v;
        tx_wr = 1'b1;
        @(negedge clock);
        tx_wr = 1'b0;
        @(negedge clock);
    endtask
    task automatic get_char();
        int k;
        for (k = 0; k < 400 && st.rx_char_avail !== 1'b1; k++) @(negedge clock);
        if (k == 400) begin
            failures++;
            results();
        end
    endtask
    task automatic read_clear();
        rx_rd = 1'b1;
        @(negedge clock);
        rx_rd = 1'b0;
        command(4'h8);
    endtask
    function automatic logic chk_of(input logic [2:0] m, input logic [7:0] v, input logic a);
        case (m)
            3'h0: return ^v;
            3'h1: return ~^v;
            3'h3: return 1'b1;
            3'h6, 3'h7: return a;
            default: return 1'b0;
        endcase
    endfunction
    // A hang in any handshake ends the run as a failure.
    initial begin
        repeat (90000) @(posedge clock);
        failures++;
        results();
    end
    initial begin
        failures = 0;
        cmp_count = 0;
        nrst = 1'b0;
        mode = '0;
        gap_len = 8'h00;
        idle_lim = 16'h0000;
        cmd_bits = '0;
        cmd_wr = 1'b0;
        tx_data = 9'h000;
        tx_wr = 1'b0;
        rx_rd = 1'b0;
        repeat (20) @(negedge clock);
        nrst = 1'b1;
        repeat (2) @(negedge clock);
        cmp_val({3'h0, st}, 9'h006);
        cmp_bit(txd, 1'b1);
        $display("test reset done");
        // Stop bit stands where a check bit would be when parity is off.
        for (int m = 0; m < 8; m++) begin
            set_mode(3'(m), 4'h8, 1'b0);
            hc = (m != 4 && m != 5);
            for (int j = 0; j < 2; j++) begin
                e = 8'(8'h41 + 2 * j);
                if (m > 5 && j == 1) command(4'h4);
                fork
                    write({1'b0, e});
                    usr_remote_i.recv(8, d, c, g);
                join
                cmp_val({1'b0, d}, {1'b0, e});
                cmp_bit(c, hc ? chk_of(3'(m), e, m > 5 && j == 1) : 1'b1);
            end
        end
        $display("test tx check bits done");
        for (int m = 0; m < 8; m++) begin
            set_mode(3'(m), 4'h8, 1'b0);
            hc = (m != 4 && m != 5);
            for (int j = 0; j < 2; j++) begin
                usr_remote_i.send(9'h041, 8, 1'b0, hc, j[0]);
                get_char();
                cmp_val(rx_data, 9'h041);
                cmp_bit(st.check_bit_error_flag, hc && (j[0] !== chk_of(3'(m), 8'h41, 1'b0)));
                read_clear();
                cmp_val({3'h0, st}, 9'h006);
            end
        end
        $display("test rx check bits done");
        set_mode(3'h0, 4'h7, 1'b1);
        usr_remote_i.send(9'h035, 7, 1'b1, 1'b1, ^7'h35);
        usr_remote_i.send(9'h05A, 7, 1'b1, 1'b1, ^7'h5A);
        repeat (2) @(negedge clock);
        cmp_val(rx_data, 9'h05A);
        cmp_bit(st.rx_overrun_flag, 1'b1);
        cmp_bit(st.check_bit_error_flag, 1'b0);
        read_clear();
        cmp_bit(st.rx_overrun_flag, 1'b0);
        $display("test overrun done");
        set_mode(3'h0, 4'h8, 1'b0);
        gap_len = 8'(GAP);
        n = 0;
        fork
            begin
                for (int i = 0; i < 12; i++) if (tx_rdy === 1'b1) begin
                    write(9'(8'h30 + n));
                    n++;
                end
                cmp_bit(tx_rdy, 1'b0);
            end
            for (int j = 0; j == 0 || j < n; j++) begin
                usr_remote_i.recv(8, d, c, g);
                cmp_val({1'b0, d}, 9'(8'h30 + j));
                if (j > 0) cmp_val(9'(g), 9'(GAP));
            end
        join
        @(negedge clock);
        cmp_bit(st.tx_all_done, 1'b0);
        tick(1);
        cmp_bit(st.tx_all_done, 1'b0);
        tick(GAP + 1);
        cmp_bit(st.tx_all_done, 1'b1);
        gap_len = 8'h00;
        $display("test idle gap done");
        tick(30);
        cmp_bit(st.rx_idle_flag, 1'b0);
        idle_lim = 16'h0005;
        command(4'h2);
        tick(20);
        cmp_bit(st.rx_idle_flag, 1'b0);
        usr_remote_i.send(9'h011, 8, 1'b0, 1'b1, 1'b0);
        get_char();
        tick(3);
        cmp_bit(st.rx_idle_flag, 1'b0);
        tick(5);
        cmp_bit(st.rx_idle_flag, 1'b1);
        command(4'h1);
        cmp_bit(st.rx_idle_flag, 1'b0);
        tick(3);
        cmp_bit(st.rx_idle_flag, 1'b0);
        tick(5);
        cmp_bit(st.rx_idle_flag, 1'b1);
        $display("test time-out done");
        results();
    end
endmodule // test_usr_serial
`default_nettype wire
